/* File: src/fcor_pkg.sv */
package fcor_pkg;

    // byte addresses of the registers on the AXI4-Lite port
    localparam logic [7:0] FCOR_ADDR_DIVIDER = 8'h00;
    localparam logic [7:0] FCOR_ADDR_OPTIONS = 8'h04;
    localparam logic [7:0] FCOR_ADDR_KEYCTL = 8'h08;
    localparam logic [7:0] FCOR_ADDR_KEYDATA = 8'h0c;
    localparam logic [7:0] FCOR_ADDR_STATUS = 8'h10;

    // divider register fields
    localparam int FCOR_DIV_WRITTEN_BIT = 7;
    localparam int FCOR_DIV_PRESCALE_BIT = 6;
    localparam int FCOR_DIV_RATIO_MSB = 5;

    // options register fields
    localparam int FCOR_OPT_BACKDOOR_BIT = 7;
    localparam int FCOR_OPT_REDIRECT_BIT = 6;
    localparam int FCOR_OPT_SEC_MSB = 1;

    // key control register fields
    localparam int FCOR_KEY_ACCESS_BIT = 0;

    // status register fields
    localparam int FCOR_STAT_SECURE_BIT = 0;
    localparam int FCOR_STAT_PE_ALLOWED_BIT = 1;
    localparam int FCOR_STAT_REDIRECT_BIT = 2;
    localparam int FCOR_STAT_KEYBAD_BIT = 3;

    // divider reset value and other fixed constants
    localparam logic [7:0] FCOR_DIVIDER_RESET = 8'h00;
    localparam logic [1:0] FCOR_SEC_UNSECURED = 2'h2;
    localparam logic [2:0] FCOR_PRESCALE_LAST = 3'h7;
    localparam logic [3:0] FCOR_KEY_BYTES = 4'h8;

    // AXI response codes
    localparam logic [1:0] FCOR_RESP_OKAY = 2'h0;
    localparam logic [1:0] FCOR_RESP_SLVERR = 2'h2;

    // security decode: only the code 1:0 is unsecured
    function automatic logic fcor_is_secure(input logic [1:0] code);
        fcor_is_secure = (code != FCOR_SEC_UNSECURED);
    endfunction : fcor_is_secure

endpackage : fcor_pkg

/* File: src/fcor_clock_divider.sv */
module fcor_clock_divider
    import fcor_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic prescaleByEight,
    input wire logic [5:0] ratio,
    output logic flashTick
);

    typedef struct packed {
        logic [2:0] pre;
        logic [5:0] cnt;
        logic tick;
    } fcor_div_state_t;

    fcor_div_state_t s_q;
    fcor_div_state_t s_d;

    // prescaler gives one enable per 8 bus clocks when prescaleByEight is set, else one per bus clock; the ratio counter then
    // counts ratio+1 enables; tick is one bus cycle per flash clock period
    always_comb
    begin
        logic preStep;
        preStep = 1'b0;
        s_d = s_q;
        s_d.tick = 1'b0;
        if (prescaleByEight) // RULE4
        begin
            s_d.pre = s_q.pre + 3'h1;
            preStep = (s_q.pre == FCOR_PRESCALE_LAST);
        end
        else
        begin
            s_d.pre = 3'h0;
            preStep = 1'b1;
        end
        if (preStep)
        begin
            if (s_q.cnt >= ratio) // RULE5
            begin
                s_d.cnt = 6'h00;
                s_d.tick = 1'b1; // RULE6
            end
            else
            begin
                s_d.cnt = s_q.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign flashTick = s_q.tick;

endmodule : fcor_clock_divider

/* File: src/fcor_flash_config.sv */
// How it works
// RULE1 - divider low bits writable once after reset
// RULE2 - written flag set by first write
// RULE3 - no program/erase until divider written
// RULE4 - prescale selects bus clock or /8
// RULE5 - flash clock is input over ratio+1
// RULE6 - timing pulse is one flash clock
// RULE7 - software keeps flash clock 150-200 kHz
// RULE8 - option byte copied into options at reset
// RULE9 - key unlocks only when backdoor enabled
// RULE10 - debug commands cannot supply key bytes
// RULE11 - options bit 6 disables vector redirection
// RULE12 - only security code 1:0 is unsecured
// RULE13 - secure blocks unsecured memory requesters
// RULE14 - key match or blank check unsecures
// RULE15 - registers present; option byte reset-copied
// RULE16 - blocked writes dropped, blocked reads zero
// RULE17 - software: key access, eight bytes, clear
// RULE18 - software writes cannot change options
module fcor_flash_config
    import fcor_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // nonvolatile option byte and key, stable from the flash array
    input wire logic [7:0] optionNvByte,
    input wire logic [63:0] nvUnlockKey,
    // blank check of the whole flash completed with success (pulse)
    input wire logic blankCheckPass,
    // program/erase request from the sequencer and its verdict
    input wire logic peRequest,
    output logic peGrant,
    output logic peRefused,
    output logic flashTick,
    // memory access filter for secure RAM and flash
    input wire logic memReqValid,
    input wire logic memReqWrite,
    input wire logic memReqTrusted,
    input wire logic [7:0] memReadData,
    output logic memWriteEnable,
    output logic [7:0] memReadDataOut,
    output logic redirectEnable,
    output logic secure
);

    typedef struct packed {
        logic [7:0] divider;
        logic [7:0] options;
        logic loaded;
        logic keyAccess;
        logic [3:0] keyIdx;
        logic keyBad;
        logic keyLast;
        logic awHeld;
        logic [7:0] awAddr;
        logic awPriv;
        logic wHeld;
        logic [7:0] wData;
        logic wLane;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic grant;
        logic refused;
        logic [7:0] memData;
        logic memWe;
    } fcor_state_t;

    fcor_state_t s_q;
    fcor_state_t s_d;
    logic [7:0] optSync1;
    logic [7:0] optSync2;
    logic divTick;

    // ratio counter and prescaler in their own module
    fcor_clock_divider u_div (
        .clk(clk),
        .rst(rst),
        .prescaleByEight(s_q.divider[FCOR_DIV_PRESCALE_BIT]),
        .ratio(s_q.divider[FCOR_DIV_RATIO_MSB:0]),
        .flashTick(divTick)
    );

    // option byte comes from the array, two flops before any use
    // no reset on purpose: the pair keeps sampling while rst is high,
    // so the byte is already settled on the first edge after release;
    // a cleared pair would hand zeros to the one-shot load instead
    // limitation: the byte must stand at least two cycles before release
    // and the load only ever happens once per reset
    always_ff @(posedge clk)
    begin
        optSync1 <= optionNvByte;
        optSync2 <= optSync1;
    end

    // byte n of the stored key, byte 0 in the low lane
    function automatic logic [7:0] keyByte(input logic [63:0] k, input logic [3:0] n);
        keyByte = k[8 * n[2:0] +: 8];
    endfunction : keyByte

    function automatic logic [31:0] readMux(input fcor_state_t st, input logic [7:0] a);
        readMux = 32'h0000_0000;
        case (a)
            FCOR_ADDR_DIVIDER: readMux = {24'h000000, st.divider}; // RULE1
            FCOR_ADDR_OPTIONS: readMux = {24'h000000, st.options};
            FCOR_ADDR_KEYCTL: readMux = {31'h0, st.keyAccess};
            FCOR_ADDR_STATUS: readMux = {28'h0, st.keyBad,
                ~st.options[FCOR_OPT_REDIRECT_BIT], st.divider[FCOR_DIV_WRITTEN_BIT],
                fcor_is_secure(st.options[FCOR_OPT_SEC_MSB:0])};
            default: readMux = 32'h0000_0000;
        endcase
    endfunction : readMux

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == FCOR_ADDR_DIVIDER) || (a == FCOR_ADDR_OPTIONS)
            || (a == FCOR_ADDR_KEYCTL) || (a == FCOR_ADDR_KEYDATA)
            || (a == FCOR_ADDR_STATUS);
    endfunction : mapped

    // whole next-state logic
    always_comb
    begin
        logic doWrite;
        logic isSecure;
        logic [7:0] keyWr;
        doWrite = 1'b0;
        isSecure = 1'b0;
        keyWr = 8'h00;
        s_d = s_q;

        // option byte taken once, on the first cycle after reset release
        if (!s_q.loaded)
        begin
            s_d.options = optSync2; // RULE8 RULE15
            s_d.loaded = 1'b1;
        end

        // write channels may arrive in either order
        if (s_axi_awvalid && !s_q.awHeld && !s_q.bValid)
        begin
            s_d.awHeld = 1'b1;
            s_d.awAddr = {s_axi_awaddr[7:2], 2'b00};
            s_d.awPriv = s_axi_awprot[0];
        end
        if (s_axi_wvalid && !s_q.wHeld && !s_q.bValid)
        begin
            s_d.wHeld = 1'b1;
            s_d.wData = s_axi_wdata[7:0];
            s_d.wLane = s_axi_wstrb[0];
        end

        if (s_q.awHeld && s_q.wHeld)
        begin
            doWrite = s_q.wLane;
            s_d.awHeld = 1'b0;
            s_d.wHeld = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = mapped(s_q.awAddr) ? FCOR_RESP_OKAY : FCOR_RESP_SLVERR;
        end
        if (s_q.bValid && s_axi_bready)
        begin
            s_d.bValid = 1'b0;
        end

        if (doWrite)
        begin
            case (s_q.awAddr)
                FCOR_ADDR_DIVIDER:
                begin
                    if (!s_q.divider[FCOR_DIV_WRITTEN_BIT])
                    begin
                        s_d.divider[FCOR_DIV_PRESCALE_BIT:0] = s_q.wData[6:0]; // RULE1
                        s_d.divider[FCOR_DIV_WRITTEN_BIT] = 1'b1; // RULE2
                    end
                end
                FCOR_ADDR_KEYCTL:
                begin
                    // awprot[0] set marks a privileged, firmware access; debug is not
                    if (s_q.awPriv) // RULE10
                    begin
                        s_d.keyAccess = s_q.wData[FCOR_KEY_ACCESS_BIT];
                        if (s_q.wData[FCOR_KEY_ACCESS_BIT])
                        begin
                            s_d.keyIdx = 4'h0;
                            s_d.keyBad = 1'b0;
                        end
                        else if (s_q.keyAccess && !s_q.keyBad && s_q.keyIdx == FCOR_KEY_BYTES
                            && s_q.options[FCOR_OPT_BACKDOOR_BIT]) // RULE9
                        begin
                            s_d.options[FCOR_OPT_SEC_MSB:0] = FCOR_SEC_UNSECURED; // RULE14
                        end
                    end
                end
                FCOR_ADDR_KEYDATA:
                begin
                    keyWr = s_q.wData;
                    // bytes are checked in order; an extra byte spoils the attempt
                    if (s_q.keyAccess && s_q.awPriv) // RULE10 RULE17
                    begin
                        if (s_q.keyIdx == FCOR_KEY_BYTES
                            || keyWr != keyByte(nvUnlockKey, s_q.keyIdx))
                        begin
                            s_d.keyBad = 1'b1;
                        end
                        else
                        begin
                            s_d.keyIdx = s_q.keyIdx + 4'h1;
                        end
                    end
                end
                // options stay read-only to software
                default: ; // RULE18
            endcase
        end

        // blank check wins over nothing; it only ever unsecures
        if (blankCheckPass && s_q.loaded)
        begin
            s_d.options[FCOR_OPT_SEC_MSB:0] = FCOR_SEC_UNSECURED; // RULE14
        end

        // read channel, one cycle from address to data
        s_d.keyLast = 1'b0;
        if (s_axi_arvalid && !s_q.rValid)
        begin
            s_d.rValid = 1'b1;
            s_d.rData = readMux(s_q, {s_axi_araddr[7:2], 2'b00});
            s_d.rResp = mapped({s_axi_araddr[7:2], 2'b00}) ? FCOR_RESP_OKAY : FCOR_RESP_SLVERR;
        end
        else if (s_q.rValid && s_axi_rready)
        begin
            s_d.rValid = 1'b0;
        end

        // program/erase verdict one cycle after the request
        s_d.grant = peRequest && s_q.divider[FCOR_DIV_WRITTEN_BIT]; // RULE3
        s_d.refused = peRequest && !s_q.divider[FCOR_DIV_WRITTEN_BIT]; // RULE3

        // secure memory filter: untrusted requesters see zeros, writes dropped
        isSecure = fcor_is_secure(s_q.options[FCOR_OPT_SEC_MSB:0]) || !s_q.loaded; // RULE12
        s_d.memWe = memReqValid && memReqWrite && (memReqTrusted || !isSecure); // RULE13 RULE16
        s_d.memData = (memReqValid && !memReqWrite && (memReqTrusted || !isSecure))
            ? memReadData : 8'h00; // RULE16
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.divider <= FCOR_DIVIDER_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // handshake outputs
    assign s_axi_awready = !s_q.awHeld && !s_q.bValid;
    assign s_axi_wready = !s_q.wHeld && !s_q.bValid;
    assign s_axi_arready = !s_q.rValid;
    assign s_axi_bvalid = s_q.bValid;
    assign s_axi_bresp = s_q.bResp;
    assign s_axi_rvalid = s_q.rValid;
    assign s_axi_rdata = s_q.rData;
    assign s_axi_rresp = s_q.rResp;

    // device side outputs
    assign peGrant = s_q.grant;
    assign peRefused = s_q.refused;
    assign flashTick = divTick && s_q.divider[FCOR_DIV_WRITTEN_BIT]; // RULE6
    assign memWriteEnable = s_q.memWe;
    assign memReadDataOut = s_q.memData;
    assign redirectEnable = !s_q.options[FCOR_OPT_REDIRECT_BIT]; // RULE11
    assign secure = fcor_is_secure(s_q.options[FCOR_OPT_SEC_MSB:0]) || !s_q.loaded; // RULE12

endmodule : fcor_flash_config

/* File: dv/fcor_monitor.sv */
module fcor_monitor
    import fcor_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic blankCheckPass,
    input wire logic peRequest,
    input wire logic peGrant,
    input wire logic peRefused,
    input wire logic flashTick,
    input wire logic memReqValid,
    input wire logic memReqWrite,
    input wire logic memReqTrusted,
    input wire logic [7:0] memReadData,
    input wire logic memWriteEnable,
    input wire logic [7:0] memReadDataOut,
    input wire logic secure
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // every sequencer request gets exactly one verdict
    pe_verdict_a: assert property (peRequest |=> peGrant ^ peRefused)
        else $error("pe request without single verdict");
    verdict_cause_a: assert property ((peGrant || peRefused) |-> $past(peRequest))
        else $error("pe verdict without request");
    // unsecured state lasts until the next reset
    unsecure_stays_a: assert property (!secure |=> !secure)
        else $error("secure returned without reset");
    blank_unsecure_a: assert property (blankCheckPass |-> ##[1:2] !secure)
        else $error("blank check did not unsecure");
    // untrusted requests see nothing while secure
    block_write_a: assert property ((memReqValid && memReqWrite && !memReqTrusted && secure)
        ##1 secure |-> !memWriteEnable)
        else $error("blocked write reached memory");
    block_read_a: assert property ((memReqValid && !memReqWrite && !memReqTrusted && secure)
        ##1 secure |-> memReadDataOut == 8'h00)
        else $error("blocked read returned data");
    trusted_read_a: assert property (memReqValid && !memReqWrite && memReqTrusted
        |=> memReadDataOut == $past(memReadData))
        else $error("trusted read data lost");
    trusted_write_a: assert property (memReqValid && memReqWrite && memReqTrusted
        |=> memWriteEnable)
        else $error("trusted write dropped");

    // main scenarios reached
    grant_c: cover property (peGrant);
    unsecure_c: cover property ($fell(secure));
    tick_c: cover property (flashTick);
endmodule : fcor_monitor

/* File: dv/tb_flash_clock_and_option_regs.sv */
module tb_flash_clock_and_option_regs
    import fcor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst = 1'h1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, optionNvByte = '0, memReadData = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, blankCheckPass = 1'h0, peRequest = 1'h0;
    logic memReqValid = 1'h0, memReqWrite = 1'h0, memReqTrusted = 1'h0;
    logic [63:0] nvUnlockKey = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic peGrant, peRefused, flashTick, memWriteEnable, redirectEnable, secure;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] memReadDataOut;
    int miscompares = 0, tests_run = 0, seed = 32'h4eda;

    always #2 clk = ~clk;

    fcor_flash_config i_dut (.*);

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // a bounded wait that ran dry ends the run
    task automatic tmo(input int n);
        if (n >= 200)
        begin
            chk("timeout", 32'h0, 32'h1);
            tally_and_finish();
        end
    endtask : tmo

    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] p);
        int n;
        logic ta, tw;
        ta = 1'h1;
        tw = 1'h1;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_awprot <= p;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while ((ta || tw) && n < 200)
        begin
            @(posedge clk);
            n++;
            ta = ta && !s_axi_awready;
            tw = tw && !s_axi_wready;
            s_axi_awvalid <= ta;
            s_axi_wvalid <= tw;
        end
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!s_axi_bvalid && n < 200);
        // bready stays up: the next call raises it in this same step
        tmo(n);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!s_axi_arready && n < 200);
        s_axi_arvalid <= 1'h0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!s_axi_rvalid && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        // rready stays up: the next call raises it in this same step
        tmo(n);
    endtask : rd

    task automatic keyIn(input logic [63:0] k, input logic [2:0] p);
        wr(FCOR_ADDR_KEYCTL, 8'h01, p);
        for (int j = 0; j < 8; j++)
            wr(FCOR_ADDR_KEYDATA, k[8*j +: 8], p);
        wr(FCOR_ADDR_KEYCTL, 8'h00, p);
    endtask : keyIn

    // verdict pulse is sampled at the edge after it was registered
    task automatic pe(input logic g);
        peRequest <= 1'h1;
        @(posedge clk);
        peRequest <= 1'h0;
        @(posedge clk);
        chk("peGrant", {31'h0, g}, {31'h0, peGrant});
        chk("peRefused", {31'h0, !g}, {31'h0, peRefused});
    endtask : pe

    task automatic mem(input logic w, input logic t, input logic blk);
        logic [7:0] v;
        v = 8'($random(seed));
        memReqValid <= 1'h1;
        memReqWrite <= w;
        memReqTrusted <= t;
        memReadData <= v;
        @(posedge clk);
        memReqValid <= 1'h0;
        @(posedge clk);
        if (w)
            chk("memWriteEnable", {31'h0, !blk}, {31'h0, memWriteEnable});
        else
            chk("memReadDataOut", {24'h0, blk ? 8'h00 : v}, {24'h0, memReadDataOut});
    endtask : mem

    // one reset per security code, each with its own option byte
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] opt, dv;
        logic sec;
        int n, per;
        nvUnlockKey = {32'($random(seed)), 32'($random(seed))};
        for (int i = 0; i < 4; i++)
        begin
            sec = (i != 2);
            opt = {i != 3, i[0], 4'h0, i[1:0]};
            optionNvByte <= opt;
            rst <= 1'h1;
            repeat (20) @(posedge clk);
            rst <= 1'h0;
            repeat (3) @(posedge clk);
            wr(FCOR_ADDR_OPTIONS, ~opt, 3'h1);
            rd(FCOR_ADDR_OPTIONS, d, r);
            chk("options", {24'h0, opt}, d);
            chk("secure", {31'h0, sec}, {31'h0, secure});
            chk("redirectEnable", {31'h0, !i[0]}, {31'h0, redirectEnable});
            pe(1'h0);
            for (int m = 0; m < 4; m++)
                mem(m[0], m[1], sec && !m[1]);
            dv = 8'($random(seed)) & 8'h47;
            wr(FCOR_ADDR_DIVIDER, dv, 3'h0);
            wr(FCOR_ADDR_DIVIDER, ~dv, 3'h0);
            rd(FCOR_ADDR_DIVIDER, d, r);
            chk("divider", {24'h0, 1'h1, dv[6:0]}, d);
            rd(FCOR_ADDR_STATUS, d, r);
            chk("status", {29'h0, !i[0], 1'h1, sec}, d & 32'h7);
            pe(1'h1);
            // tick spacing taken from one tick to the next
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (!flashTick && n < 200);
            tmo(n);
            per = 0;
            do
            begin
                @(posedge clk);
                per++;
            end
            while (!flashTick && per < 200);
            chk("tick period", (dv[2:0] + 1) * (dv[6] ? 8 : 1), per);
            if (i != 2)
            begin
                keyIn(nvUnlockKey ^ {63'h0, i == 1}, 3'h1);
                keyIn(nvUnlockKey, 3'h0);
                repeat (2) @(posedge clk);
                chk("secure after key", {31'h0, i != 0}, {31'h0, secure});
                blankCheckPass <= 1'h1;
                @(posedge clk);
                blankCheckPass <= 1'h0;
                repeat (2) @(posedge clk);
                chk("secure after blank", 32'h0, {31'h0, secure});
                mem(1'h0, 1'h0, 1'h0);
            end
        end
        rd(8'h14, d, r);
        chk("unmapped resp", {30'h0, FCOR_RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        tally_and_finish();
    end
endmodule : tb_flash_clock_and_option_regs

bind fcor_flash_config fcor_monitor i_mon (.*);
